// file: design/iocfu_top.sv
// i/o command and format unit: apb register file, digital and analog i/o, reply formatter
// assumes din_in and ain_in are asynchronous to core_clk_in; apb master on core_clk_in
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iocfu_top
  import iocfu_pkg::*;
#(
  parameter int AIN_BITS = 12,
  parameter int AOUT_BITS = 12,
  parameter int DIO_BITS = 16,
  parameter int AN_CHANS = 8
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [DIO_BITS-1:0] din_in,
  output logic [DIO_BITS-1:0] dout_out,
  input wire logic [AN_CHANS*AIN_BITS-1:0] ain_in,
  output logic [AN_CHANS*AOUT_BITS-1:0] aout_out,
  output logic ain_diff_out,
  output logic stall_out
);
  initial
  begin
    if (DIO_BITS != 16 || AN_CHANS != 8 || !(AIN_BITS == 12 || AIN_BITS == 16) || AOUT_BITS < 12 || AOUT_BITS > 16)
      $error("iocfu_top: unsupported parameter values");
  end
  // ==========================================================
  // reset release and input synchronisers
  logic [1:0] rst_sync;
  logic rstn;
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rstn = rst_sync[1];
  logic [DIO_BITS-1:0] din_s1, din_s2;
  logic [AN_CHANS*AIN_BITS-1:0] ain_s1, ain_s2;
  always_ff @(posedge core_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      din_s1 <= '0;
      din_s2 <= '0;
      ain_s1 <= '0;
      ain_s2 <= '0;
    end
    else
    begin
      din_s1 <= din_in;
      din_s2 <= din_s1;
      ain_s1 <= ain_in;
      ain_s2 <= ain_s1;
    end
  end
  // ==========================================================
  // bus decode
  logic setup, acc, wr;
  assign setup = psel_in && !penable_in;
  assign acc = psel_in && penable_in;
  assign wr = acc && pwrite_in;
  assign pready_out = 1'b1;
  // ==========================================================
  // control and i/o state
  logic zs, diff;
  logic signed [4:0] g_int;
  logic [2:0] g_frac;
  logic [15:0] loc;
  logic [31:0] val;
  logic [13:0] frac;
  logic [47:0] str;
  logic [DIO_BITS-1:0] dout, actlvl, trip_mask, trip_lvl;
  logic [3:0] bit_sel, inbit_sel;
  logic [2:0] ain_sel, aout_sel, atrip_ch;
  logic atrip_dir, in_wait, an_wait;
  logic [15:0] atrip_thr;
  logic [AOUT_BITS-1:0] aout [AN_CHANS];
  logic [DIO_BITS-1:0] din_act;
  assign din_act = din_s2 ~^ actlvl;
  function automatic logic [15:0] ain_code(input logic [AN_CHANS*AIN_BITS-1:0] a, input logic [2:0] ch,
                                           input logic d);
    logic [15:0] r;
    r = '0;
    if (!d) r[AIN_BITS-1:0] = a[ch*AIN_BITS+:AIN_BITS];
    else if (ch < 3'd4) r[AIN_BITS-1:0] = a[{ch[1:0], 1'b0}*AIN_BITS+:AIN_BITS];
    return r;
  endfunction
  function automatic logic in_ok(input logic [DIO_BITS-1:0] act, input logic [DIO_BITS-1:0] m,
                                 input logic [DIO_BITS-1:0] l);
    return ((act ~^ l) & m) == m;
  endfunction
  function automatic logic an_ok(input logic [15:0] code, input logic [15:0] thr, input logic dir);
    return dir ? (code < thr) : (code > thr);
  endfunction
  logic [15:0] atrip_code;
  assign atrip_code = ain_code(ain_s2, atrip_ch, diff);
  always_ff @(posedge core_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      zs <= RST_ZERO_SUPPRESS;
      g_int <= RST_INT_DIGITS;
      g_frac <= RST_FRAC_DIGITS;
      diff <= 1'b0;
    end
    else if (wr && paddr_in == OFS_CTRL)
    begin
      zs <= pwdata_in[CTRL_ZS];
      diff <= pwdata_in[CTRL_DIFF];
      if ($signed(pwdata_in[CTRL_INT_LSB+:5]) <= 5'sd10 && $signed(pwdata_in[CTRL_INT_LSB+:5]) >= -5'sd10)
        g_int <= $signed(pwdata_in[CTRL_INT_LSB+:5]);
      if (pwdata_in[CTRL_FRAC_LSB+:3] <= 3'd4)
        g_frac <= pwdata_in[CTRL_FRAC_LSB+:3];
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      dout <= '0;
      bit_sel <= '0;
    end
    else if (wr && paddr_in == OFS_DOUT)
      dout <= pwdata_in[DIO_BITS-1:0];
    else if (wr && paddr_in == OFS_BITCMD)
    begin
      bit_sel <= pwdata_in[3:0];
      case (pwdata_in[BC_OP_LSB+:2])
        BC_SET: dout[pwdata_in[3:0]] <= 1'b1;
        BC_CLR: dout[pwdata_in[3:0]] <= 1'b0;
        BC_COND: dout[pwdata_in[3:0]] <= |pwdata_in[31:BC_OPND_LSB];
        default: dout <= dout;
      endcase
    end
  end
  assign dout_out = dout;
  always_ff @(posedge core_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      actlvl <= {DIO_BITS{1'b1}};
      inbit_sel <= '0;
      trip_mask <= '0;
      trip_lvl <= '0;
      in_wait <= 1'b0;
    end
    else
    begin
      if (wr && paddr_in == OFS_ACTLVL) actlvl <= pwdata_in[DIO_BITS-1:0];
      if (wr && paddr_in == OFS_INBIT) inbit_sel <= pwdata_in[3:0];
      if (wr && paddr_in == OFS_INTRIP)
      begin
        trip_mask <= pwdata_in[15:0];
        trip_lvl <= pwdata_in[31:16];
        in_wait <= !in_ok(din_act, pwdata_in[15:0], pwdata_in[31:16]);
      end
      else if (in_wait && in_ok(din_act, trip_mask, trip_lvl)) in_wait <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      atrip_ch <= '0;
      atrip_dir <= 1'b0;
      atrip_thr <= '0;
      an_wait <= 1'b0;
      ain_sel <= '0;
      aout_sel <= '0;
      for (int i = 0; i < AN_CHANS; i++) aout[i] <= '0;
    end
    else
    begin
      if (wr && paddr_in == OFS_AIN) ain_sel <= pwdata_in[2:0];
      if (wr && paddr_in == OFS_AOUT)
      begin
        aout_sel <= pwdata_in[2:0];
        aout[pwdata_in[2:0]] <= pwdata_in[CODE_LSB+:AOUT_BITS];
      end
      if (wr && paddr_in == OFS_ANTRIP)
      begin
        atrip_ch <= pwdata_in[2:0];
        atrip_dir <= pwdata_in[ATRIP_DIR];
        atrip_thr <= pwdata_in[CODE_LSB+:16];
        an_wait <= !an_ok(ain_code(ain_s2, pwdata_in[2:0], diff), pwdata_in[CODE_LSB+:16],
                          pwdata_in[ATRIP_DIR]);
      end
      else if (an_wait && an_ok(atrip_code, atrip_thr, atrip_dir)) an_wait <= 1'b0;
    end
  end
  for (genvar g = 0; g < AN_CHANS; g++)
  begin : g_aout
    assign aout_out[g*AOUT_BITS+:AOUT_BITS] = aout[g];
  end
  assign ain_diff_out = diff;
  assign stall_out = in_wait || an_wait;
  // ==========================================================
  // reply formatter: binary to bcd, then one character per reply read
  iocfu_st_t st;
  iocfu_em_t em;
  logic [39:0] bcd;
  logic [31:0] sh;
  logic [5:0] cnt;
  logic [15:0] fbcd;
  logic [3:0] idx, f_n, lead;
  logic [2:0] f_m, f_sn;
  logic f_hex, f_str, f_neg, f_zs, ovf, pop;
  logic [7:0] ch;
  function automatic logic [39:0] dd_adj(input logic [39:0] b);
    logic [39:0] r;
    r = b;
    for (int i = 0; i < MAX_INT_DIGITS; i++)
      if (r[i*4+:4] >= 4'd5) r[i*4+:4] = r[i*4+:4] + 4'd3;
    return r;
  endfunction
  function automatic logic [3:0] lead_of(input logic [39:0] b);
    logic [3:0] r;
    r = '0;
    for (int i = 1; i < MAX_INT_DIGITS; i++)
      if (b[i*4+:4] != 4'd0) r = 4'(i);
    return r;
  endfunction
  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    return (n < 4'd10) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction
  assign lead = lead_of(bcd);
  assign ovf = (lead >= f_n) && (bcd[lead*4+:4] != 4'd0) && !f_hex;
  assign pop = acc && !pwrite_in && paddr_in == OFS_REPLY && st == ST_EMIT;
  logic [39:0] adj;
  assign adj = dd_adj(bcd);
  logic start;
  assign start = wr && paddr_in == OFS_VALUE;
  always_ff @(posedge core_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      val <= '0;
      frac <= '0;
      loc <= '0;
      str <= '0;
      f_hex <= 1'b0;
      f_str <= 1'b0;
      f_neg <= 1'b0;
      f_zs <= 1'b1;
      f_n <= '0;
      f_m <= '0;
      f_sn <= '0;
    end
    else
    begin
      if (wr && paddr_in == OFS_FRAC && pwdata_in[13:0] < 14'd10000) frac <= pwdata_in[13:0];
      if (wr && paddr_in == OFS_STR_LO) str[31:0] <= pwdata_in;
      if (wr && paddr_in == OFS_STR_HI) str[47:32] <= pwdata_in[15:0];
      if (wr && paddr_in == OFS_LOCAL) loc <= pwdata_in[15:0];
      else if (start) loc[LOC_EN] <= 1'b0;
      if (start && st == ST_IDLE)
      begin
        val <= pwdata_in;
        f_zs <= zs;
        f_str <= loc[LOC_EN] && loc[LOC_STR];
        f_sn <= (loc[2:0] > 3'd6 || loc[2:0] == 3'd0) ? 3'd6 : loc[2:0];
        if (loc[LOC_EN])
        begin
          f_hex <= loc[LOC_HEX];
          f_n <= (loc[LOC_INT_LSB+:4] > 4'd10) ? 4'd10 : loc[LOC_INT_LSB+:4];
          f_m <= (loc[LOC_FRAC_LSB+:3] > 3'd4) ? 3'd4 : loc[LOC_FRAC_LSB+:3];
          f_neg <= pwdata_in[31] && !loc[LOC_HEX];
        end
        else
        begin
          f_hex <= g_int < 0;
          f_n <= (g_int < 0) ? 4'(-g_int) : 4'(g_int);
          f_m <= g_frac;
          f_neg <= pwdata_in[31] && !(g_int < 0);
        end
      end
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= ST_IDLE;
      em <= EM_PRE;
      bcd <= '0;
      sh <= '0;
      cnt <= '0;
      fbcd <= '0;
      idx <= '0;
    end
    else
      case (st)
        ST_IDLE:
          if (start)
          begin
            bcd <= '0;
            sh <= {18'h0, frac};
            cnt <= '0;
            st <= (loc[LOC_EN] && loc[LOC_STR]) ? ST_EMIT : ST_FRAC;
            em <= EM_STR;
            idx <= '0;
          end
        ST_FRAC, ST_INT:
        begin
          {bcd, sh} <= {adj[38:0], sh, 1'b0};
          cnt <= cnt + 6'd1;
          if (cnt == 6'(CONV_STEPS - 1))
          begin
            cnt <= '0;
            if (st == ST_FRAC)
            begin
              fbcd <= adj[14:0] << 1 | {15'h0, sh[31]};
              bcd <= '0;
              sh <= val[31] && f_neg ? 32'(-val) : val;
              st <= ST_INT;
            end
            else st <= ST_EMIT;
          end
        end
        ST_EMIT:
          if (em == EM_STR && cnt == 6'd0 && !f_str)
          begin
            cnt <= 6'd1;
            em <= (f_hex || f_neg) ? EM_PRE : (f_n != 4'd0) ? EM_INT : EM_DOT;
            idx <= (f_zs && !ovf && !f_hex && lead < f_n) ? lead : f_n - 4'd1;
            if (!(f_hex || f_neg) && f_n == 4'd0 && f_m == 3'd0) st <= ST_IDLE;
          end
          else if (pop)
            case (em)
              EM_STR:
                if (idx == 4'(f_sn - 3'd1)) st <= ST_IDLE;
                else idx <= idx + 4'd1;
              EM_PRE:
                if (f_n != 4'd0) em <= EM_INT;
                else if (f_m != 3'd0) em <= EM_DOT;
                else st <= ST_IDLE;
              EM_INT:
                if (idx != 4'd0) idx <= idx - 4'd1;
                else if (f_m != 3'd0) em <= EM_DOT;
                else st <= ST_IDLE;
              EM_DOT:
              begin
                em <= EM_FRAC;
                idx <= 4'd3;
              end
              EM_FRAC:
                if (idx == 4'(4 - f_m)) st <= ST_IDLE;
                else idx <= idx - 4'd1;
              default: st <= ST_IDLE;
            endcase
        default: st <= ST_IDLE;
      endcase
  end
  always_comb
  begin
    ch = 8'h30;
    case (em)
      EM_PRE: ch = f_hex ? 8'h24 : 8'h2d;
      EM_INT:
        if (f_hex) ch = hex_ch(idx < 4'd8 ? val[idx[2:0]*4+:4] : {4{val[31]}});
        else if (ovf) ch = 8'h39;
        else ch = 8'h30 + {4'h0, bcd[idx*4+:4]};
      EM_DOT: ch = 8'h2e;
      EM_FRAC: ch = 8'h30 + {4'h0, fbcd[idx[1:0]*4+:4]};
      EM_STR: ch = str[idx*8+:8];
      default: ch = 8'h30;
    endcase
  end
  // ==========================================================
  // read mux, latched in the setup cycle
  logic [15:0] rcode;
  assign rcode = ain_code(ain_s2, ain_sel, diff);
  always_ff @(posedge core_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata_out <= '0;
      pslverr_out <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_out <= 1'b0;
      prdata_out <= '0;
      case (paddr_in)
        OFS_CTRL: prdata_out <= {15'h0, diff, 1'b0, g_frac, 3'h0, g_int, 3'h0, zs};
        OFS_VALUE: prdata_out <= val;
        OFS_FRAC: prdata_out <= {18'h0, frac};
        OFS_LOCAL: prdata_out <= {16'h0, loc};
        OFS_REPLY: prdata_out <= {23'h0, st == ST_EMIT && !(em == EM_STR && cnt == 6'd0 && !f_str), ch};
        OFS_STR_LO: prdata_out <= str[31:0];
        OFS_STR_HI: prdata_out <= {16'h0, str[47:32]};
        OFS_DOUT: prdata_out <= {16'h0, dout};
        OFS_BITCMD: prdata_out <= {31'h0, dout[bit_sel]};
        OFS_DIN: prdata_out <= {16'h0, din_act};
        OFS_INBIT: prdata_out <= {16'h0, din_act[inbit_sel[3] * 8+:8], 7'h0, din_act[inbit_sel]};
        OFS_ACTLVL: prdata_out <= {16'h0, actlvl};
        OFS_INTRIP: prdata_out <= {31'h0, in_wait};
        OFS_ANTRIP: prdata_out <= {31'h0, an_wait};
        OFS_AIN: prdata_out <= {16'h0, rcode};
        OFS_AREC: prdata_out <= 32'(rcode[AIN_BITS-1-:12]) << REC_SHIFT;
        OFS_AOUT: prdata_out <= {16'h0, 16'(aout[aout_sel])};
        default: pslverr_out <= 1'b1;
      endcase
    end
  end
  // ==========================================================
  // checks
  chk_zs_reset: assert property (@(posedge core_clk_in) $rose(rstn) |-> zs && g_int == 5'sd10 && g_frac == 3'd4)
    else $error("format reset value wrong");
  chk_set_bit: assert property (@(posedge core_clk_in) disable iff (!rstn)
    wr && paddr_in == OFS_BITCMD && pwdata_in[5:4] == BC_SET |=> dout[$past(pwdata_in[3:0])])
    else $error("set bit not applied");
  chk_clr_other: assert property (@(posedge core_clk_in) disable iff (!rstn)
    wr && paddr_in == OFS_BITCMD && pwdata_in[5:4] == BC_CLR |=> (dout | (16'h1 << $past(pwdata_in[3:0]))) ==
    ($past(dout) | (16'h1 << $past(pwdata_in[3:0]))) && !dout[$past(pwdata_in[3:0])])
    else $error("clear bit disturbed other outputs");
  chk_cond_bit: assert property (@(posedge core_clk_in) disable iff (!rstn)
    wr && paddr_in == OFS_BITCMD && pwdata_in[5:4] == BC_COND |=> dout[$past(pwdata_in[3:0])] == |$past(pwdata_in[31:8]))
    else $error("conditional bit wrong");
  chk_bank_write: assert property (@(posedge core_clk_in) disable iff (!rstn)
    wr && paddr_in == OFS_DOUT |=> dout_out == $past(pwdata_in[15:0]))
    else $error("bank write wrong");
  chk_in_trip: assert property (@(posedge core_clk_in) disable iff (!rstn)
    in_wait && !(wr && paddr_in == OFS_INTRIP) && in_ok(din_act, trip_mask, trip_lvl) |=> !in_wait)
    else $error("input trip not released");
  chk_an_pass: assert property (@(posedge core_clk_in) disable iff (!rstn)
    wr && paddr_in == OFS_ANTRIP && an_ok(ain_code(ain_s2, pwdata_in[2:0], diff), pwdata_in[31:16], pwdata_in[4])
    |=> !an_wait)
    else $error("analog trip stalled though passed");
  chk_local_once: assert property (@(posedge core_clk_in) disable iff (!rstn)
    start && !(wr && paddr_in == OFS_LOCAL) |=> !loc[LOC_EN])
    else $error("local format kept");
  chk_conv_len: assert property (@(posedge core_clk_in) disable iff (!rstn)
    st == ST_IDLE && start && !(loc[LOC_EN] && loc[LOC_STR]) |=> st == ST_FRAC ##32 st == ST_INT ##32 st == ST_EMIT)
    else $error("conversion length wrong");
  chk_in_met: assert property (@(posedge core_clk_in) disable iff (!rstn)
    wr && paddr_in == OFS_INTRIP && in_ok(din_act, pwdata_in[15:0], pwdata_in[31:16]) |=> !in_wait)
    else $error("input trip stalled though met");
  cov_reply: cover property (@(posedge core_clk_in) disable iff (!rstn) pop && em == EM_FRAC);
  cov_hex: cover property (@(posedge core_clk_in) disable iff (!rstn) pop && em == EM_PRE && f_hex);
  cov_ovf: cover property (@(posedge core_clk_in) disable iff (!rstn) pop && em == EM_INT && ovf);
  cov_trip: cover property (@(posedge core_clk_in) disable iff (!rstn) $fell(an_wait));
endmodule // iocfu_top
`default_nettype wire

// file: design/iocfu_pkg.sv
// package of the i/o command and format unit: register map, fields, reset values
// assumes a 32-bit apb master and byte addresses on word boundaries
package iocfu_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VALUE = 8'h04;
  localparam logic [7:0] OFS_FRAC = 8'h08;
  localparam logic [7:0] OFS_LOCAL = 8'h0c;
  localparam logic [7:0] OFS_REPLY = 8'h10;
  localparam logic [7:0] OFS_STR_LO = 8'h14;
  localparam logic [7:0] OFS_STR_HI = 8'h18;
  localparam logic [7:0] OFS_DOUT = 8'h20;
  localparam logic [7:0] OFS_BITCMD = 8'h24;
  localparam logic [7:0] OFS_DIN = 8'h28;
  localparam logic [7:0] OFS_INBIT = 8'h2c;
  localparam logic [7:0] OFS_ACTLVL = 8'h30;
  localparam logic [7:0] OFS_INTRIP = 8'h34;
  localparam logic [7:0] OFS_ANTRIP = 8'h38;
  localparam logic [7:0] OFS_AIN = 8'h3c;
  localparam logic [7:0] OFS_AREC = 8'h40;
  localparam logic [7:0] OFS_AOUT = 8'h44;
  // ==========================================================
  // control fields
  localparam int CTRL_ZS = 0;
  localparam int CTRL_INT_LSB = 4;
  localparam int CTRL_FRAC_LSB = 12;
  localparam int CTRL_DIFF = 16;
  // local format fields
  localparam int LOC_EN = 15;
  localparam int LOC_HEX = 14;
  localparam int LOC_STR = 13;
  localparam int LOC_INT_LSB = 4;
  localparam int LOC_FRAC_LSB = 0;
  // bit command fields
  localparam int BC_OP_LSB = 4;
  localparam int BC_OPND_LSB = 8;
  localparam logic [1:0] BC_SET = 2'h1;
  localparam logic [1:0] BC_CLR = 2'h2;
  localparam logic [1:0] BC_COND = 2'h3;
  // trip and analog fields
  localparam int ATRIP_DIR = 4;
  localparam int CODE_LSB = 16;
  // ==========================================================
  // limits and reset values
  localparam logic signed [4:0] RST_INT_DIGITS = 5'sd10;
  localparam logic [2:0] RST_FRAC_DIGITS = 3'd4;
  localparam logic RST_ZERO_SUPPRESS = 1'b1;
  localparam int MAX_INT_DIGITS = 10;
  localparam int MAX_FRAC_DIGITS = 4;
  localparam int MAX_STR_CHARS = 6;
  localparam int REC_SHIFT = 3;
  localparam int CONV_STEPS = 32;
  // ==========================================================
  typedef enum logic [3:0] {ST_IDLE = 4'b0001, ST_FRAC = 4'b0010, ST_INT = 4'b0100, ST_EMIT = 4'b1000} iocfu_st_t;
  typedef enum logic [4:0] {EM_PRE = 5'b00001, EM_INT = 5'b00010, EM_DOT = 5'b00100, EM_FRAC = 5'b01000,
                            EM_STR = 5'b10000} iocfu_em_t;
endpackage

// file: verification/iocfu_field_model.sv
// field side model: digital input pins and analog input codes
// assumes the bench sets the wanted pin levels; values reach pins one edge later
`timescale 1ns/1ps
`default_nettype none
module iocfu_field_model (
  input wire logic core_clk_in,
  input wire logic [15:0] want_din_in,
  input wire logic [95:0] want_ain_in,
  output logic [15:0] din_out,
  output logic [95:0] ain_out
);
  always_ff @(posedge core_clk_in)
  begin
    din_out <= want_din_in;
    ain_out <= want_ain_in;
  end
endmodule // iocfu_field_model
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench of the i/o command and format unit
// assumes apb with pready high, replies ready 66 cycles after a value write
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import iocfu_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pw = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pd = 32'h0, prd, r;
  logic prdy, perr, serr, adiff, stall;
  logic [15:0] wdin = 16'h0, din, dout;
  logic [95:0] wain = 96'h0, ain, aout;
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #20 clk = ~clk;
  iocfu_field_model fm (.core_clk_in(clk), .want_din_in(wdin), .want_ain_in(wain), .din_out(din), .ain_out(ain));
  iocfu_top dut (.core_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen), .pwrite_in(pw),
    .paddr_in(pa), .pwdata_in(pd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .din_in(din),
    .dout_out(dout), .ain_in(ain), .aout_out(aout), .ain_diff_out(adiff), .stall_out(stall));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pw <= w; pa <= a; pd <= d; pen <= 1'b0;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (prdy !== 1'b1);
    r = prd;
    serr = perr;
    psel <= 1'b0; pen <= 1'b0;
    // one more edge so outputs written at the access edge have settled
    @(posedge clk);
  endtask
  task automatic reply(input logic [31:0] ctl, input logic [31:0] loc, input string e);
    string s;
    s = "";
    apb(1'b1, OFS_CTRL, ctl);
    apb(1'b1, OFS_FRAC, 32'h0);
    apb(1'b1, OFS_LOCAL, loc);
    apb(1'b1, OFS_VALUE, 32'ha);
    repeat (70) @(posedge clk);
    for (int i = 0; i < 20; i++)
    begin
      apb(1'b0, OFS_REPLY, 32'h0);
      if (r[8] === 1'b1) s = {s, string'(r[7:0])};
    end
    total_checks++;
    if (s != e)
    begin
      n_errors++;
      $display("BAD reply expected %s seen %s", e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      tally_and_finish;
    end
  end
  // ==========================================================
  // scenarios
  task automatic t_format;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h40a1, r);
    reply(32'h40a1, 32'h0, "10.0000");
    reply(32'h40a0, 32'h0, "0000000010.0000");
    reply(32'h2020, 32'hc042, "$000A.00");
    reply(32'h40a0, 32'h8042, "0010.00");
    reply(32'h2020, 32'h0, "10.00");
    reply(32'h21e0, 32'h0, "$0A.00");
    reply(32'h0010, 32'h0, "9");
    apb(1'b1, OFS_STR_LO, 32'h48504c41);
    apb(1'b1, OFS_STR_HI, 32'h41);
    reply(32'h2020, 32'ha004, "ALPH");
  endtask
  task automatic t_dout;
    apb(1'b1, OFS_DOUT, 32'h0700);
    chk("bank write", 32'h0700, {16'h0, dout});
    apb(1'b1, OFS_BITCMD, 32'h12);
    apb(1'b1, OFS_BITCMD, 32'h29);
    chk("set clear", 32'h0504, {16'h0, dout});
    apb(1'b1, OFS_BITCMD, 32'h530);
    apb(1'b1, OFS_BITCMD, 32'h32);
    chk("conditional", 32'h0501, {16'h0, dout});
    apb(1'b0, OFS_BITCMD, 32'h0);
    chk("readback", 32'h0, {31'h0, r[0]});
    apb(1'b1, OFS_BITCMD, 32'h08);
    chk("no-op cmd", 32'h0501, {16'h0, dout});
    apb(1'b0, OFS_BITCMD, 32'h0);
    chk("readback set", 32'h1, {31'h0, r[0]});
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, serr});
  endtask
  task automatic t_din;
    @(posedge clk) wdin <= 16'h0;
    repeat (4) @(posedge clk);
    apb(1'b1, OFS_INTRIP, 32'h00080008);
    chk("trip wait", 32'h1, {31'h0, stall});
    @(posedge clk) wdin <= 16'h0808;
    repeat (6) @(posedge clk);
    chk("trip met", 32'h0, {31'h0, stall});
    apb(1'b1, OFS_INBIT, 32'hb);
    apb(1'b0, OFS_INBIT, 32'h0);
    chk("input bit bank1", 32'h0801, {16'h0, r[15:8], 7'h0, r[0]});
    apb(1'b1, OFS_INBIT, 32'h3);
    apb(1'b0, OFS_INBIT, 32'h0);
    chk("input bit bank0", 32'h0801, {16'h0, r[15:8], 7'h0, r[0]});
    apb(1'b1, OFS_ACTLVL, 32'h0);
    apb(1'b0, OFS_DIN, 32'h0);
    chk("active level", 32'hf7f7, {16'h0, r[15:0]});
  endtask
  task automatic t_analog;
    @(posedge clk) wain <= 96'h5a5 << 24;
    repeat (6) @(posedge clk);
    apb(1'b1, OFS_AIN, 32'h2);
    apb(1'b0, OFS_AIN, 32'h0);
    chk("ain code", 32'h5a5, r);
    apb(1'b0, OFS_AREC, 32'h0);
    chk("ain record", 32'h2d28, r);
    apb(1'b1, OFS_ANTRIP, 32'h01000002);
    chk("passed trip", 32'h0, {31'h0, stall});
    apb(1'b1, OFS_ANTRIP, 32'h07000002);
    chk("rise wait", 32'h1, {31'h0, stall});
    @(posedge clk) wain <= 96'h7ff << 24;
    repeat (8) @(posedge clk);
    chk("rise met", 32'h0, {31'h0, stall});
    apb(1'b1, OFS_AOUT, 32'h01230007);
    apb(1'b0, OFS_AOUT, 32'h0);
    chk("aout read", 32'h123, r);
    chk("aout pin", 32'h123, {20'h0, aout[84 +: 12]});
    apb(1'b1, OFS_CTRL, 32'h140a1);
    chk("diff mode", 32'h1, {31'h0, adiff});
    apb(1'b1, OFS_AIN, 32'h1);
    apb(1'b0, OFS_AIN, 32'h0);
    chk("diff channel", 32'h7ff, r);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_format();
    t_dout();
    t_din();
    t_analog();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
